// ==== design/cx_pkg.sv ====
package cx_pkg;
   // Opcodes
   localparam logic [7:0] OP_ST_DEC = 8'hf2;
   localparam logic [7:0] OP_ST_INC = 8'hf3;
   localparam logic [7:0] OP_LW_RR = 8'hc4;
   localparam logic [7:0] OP_LW_IR = 8'hc5;
   localparam logic [7:0] OP_LW_IM = 8'hc6;
   localparam logic [7:0] OP_MUL_R = 8'h84;
   localparam logic [7:0] OP_MUL_IR = 8'h85;
   localparam logic [7:0] OP_MUL_IM = 8'h86;
   localparam logic [7:0] OP_NEXT = 8'h0f;
   localparam logic [7:0] OP_NOP = 8'hff;
   localparam logic [7:0] OP_OR_WW = 8'h42;
   localparam logic [7:0] OP_OR_WI = 8'h43;
   localparam logic [7:0] OP_OR_RR = 8'h44;
   localparam logic [7:0] OP_OR_RI = 8'h45;
   localparam logic [7:0] OP_OR_IM = 8'h46;
   // Cycle counts
   localparam logic [4:0] CYC_STORE = 5'h0e;
   localparam logic [4:0] CYC_LW = 5'h08;
   localparam logic [4:0] CYC_MUL = 5'h16;
   localparam logic [4:0] CYC_NEXT = 5'h0a;
   localparam logic [4:0] CYC_NOP = 5'h04;
   localparam logic [4:0] CYC_OR_SHORT = 5'h04;
   localparam logic [4:0] CYC_OR_LONG = 5'h06;
   localparam logic [4:0] CYC_ILLEGAL = 5'h01;
   // Step numbers inside a run
   localparam logic [4:0] STEP_PTR = 5'h00;
   localparam logic [4:0] STEP_MEM = 5'h01;
   localparam logic [4:0] STEP_MEM_END = 5'h02;
   localparam logic [4:0] STEP_RD_HI = 5'h02;
   localparam logic [4:0] STEP_RD_LO = 5'h03;
   // Byte offsets on the register bus
   localparam logic [10:0] OFS_CTRL = 11'h000;
   localparam logic [10:0] OFS_STATUS = 11'h004;
   localparam logic [10:0] OFS_FLAGS = 11'h008;
   localparam logic [10:0] OFS_PC = 11'h00c;
   localparam logic [10:0] OFS_TPTR = 11'h010;
   localparam logic [10:0] OFS_RF = 11'h400;
   // Flag bit positions
   localparam int FL_C = 7;
   localparam int FL_Z = 6;
   localparam int FL_S = 5;
   localparam int FL_V = 4;
   localparam int FL_D = 3;
   localparam int FL_H = 2;
   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_ILLEGAL = 1;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   typedef enum logic [0:0] {
      CX_IDLE = 1'b0,
      CX_RUN = 1'b1
   } cx_state_t;

   typedef struct packed {
      logic [7:0] b3;
      logic [7:0] b2;
      logic [7:0] b1;
      logic [7:0] op;
   } cx_ins_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
      logic prog;
   } cx_mem_req_t;
endpackage

// ==== design/cx_exec.sv ====
// Behaviour
// - The pre-decrement store (F2, 2 bytes, 14 cycles) first lowers the pointer pair, then writes the source to that address.
// - An even pointer pair number sends the store to program memory, an odd one to external data memory.
// - The pre-increment store (F3, 2 bytes, 14 cycles) first raises the pointer pair, then writes the source to that address.
// - Stores, word load, next-word jump and no-operation leave all flags and the source unchanged.
// - Word load copies a 16-bit source into a destination pair: C4 pair, C5 indirect, C6 immediate, 8 cycles each.
// - Unsigned multiply takes the even destination register times the source and stores the 16-bit product in the pair.
// - Multiply sets carry above 255, zero on zero, sign from bit 15, clears overflow, keeps half-carry.
// - Multiply is 3 bytes, 22 cycles; 84 register, 85 indirect, 86 immediate source.
// - Next-word loads the program counter from the program word at the thread pointer, then adds two to it; 0F, 1 byte, 10 cycles.
// - No-operation, FF, 1 byte, changes nothing and lasts 4 cycles.
// - Logical OR writes destination OR source to the destination and keeps the source.
// - OR sets zero on zero, sign from bit 7, clears overflow, keeps carry, decimal-adjust and half-carry.
// - OR result bits are one where either operand bit is one; 42 takes 4 cycles, 43 and 46 take 6.
`timescale 1ns/10ps
module cx_exec (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [10:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output cx_pkg::cx_mem_req_t mem_req,
   input wire logic [7:0] mem_rdata,
   output logic [15:0] pc,
   output logic busy
);
   logic [7:0] rf_reg [0:255];
   cx_pkg::cx_state_t state_reg, state_next;
   cx_pkg::cx_ins_t ins_reg;
   cx_pkg::cx_mem_req_t mem_reg, mem_next;
   logic [4:0] cnt_reg, len_reg;
   logic [7:0] flags_reg, flags_next;
   logic [15:0] pc_reg, tptr_reg;
   logic [7:0] hi_reg, lo_reg;
   logic illegal_reg, wait_reg;
   logic [31:0] rdata_reg;

   // Bus decode
   wire logic req = avs_read | avs_write;
   wire logic accept = req & ~wait_reg;
   wire logic stall = avs_write & (state_reg == cx_pkg::CX_RUN);
   wire logic hit_ctrl = avs_address == cx_pkg::OFS_CTRL;
   wire logic hit_status = avs_address == cx_pkg::OFS_STATUS;
   wire logic hit_flags = avs_address == cx_pkg::OFS_FLAGS;
   wire logic hit_pc = avs_address == cx_pkg::OFS_PC;
   wire logic hit_tptr = avs_address == cx_pkg::OFS_TPTR;
   wire logic hit_rf = avs_address[10] & (avs_address[1:0] == 2'b00);
   wire logic [7:0] rf_idx = avs_address[9:2];
   wire logic sw_wr = accept & avs_write;
   wire logic launch = sw_wr & hit_ctrl & (&avs_byteenable);
   wire logic sw_rf_wr = sw_wr & hit_rf & avs_byteenable[0];

   function automatic logic [15:0] merge16(input logic [15:0] old,
         input logic [31:0] nw, input logic [3:0] be);
      merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   function automatic logic [4:0] cycles_of(input logic [7:0] op);
      case (op)
         cx_pkg::OP_ST_DEC, cx_pkg::OP_ST_INC: cycles_of = cx_pkg::CYC_STORE;
         cx_pkg::OP_LW_RR, cx_pkg::OP_LW_IR,
         cx_pkg::OP_LW_IM: cycles_of = cx_pkg::CYC_LW;
         cx_pkg::OP_MUL_R, cx_pkg::OP_MUL_IR,
         cx_pkg::OP_MUL_IM: cycles_of = cx_pkg::CYC_MUL;
         cx_pkg::OP_NEXT: cycles_of = cx_pkg::CYC_NEXT;
         cx_pkg::OP_NOP: cycles_of = cx_pkg::CYC_NOP;
         cx_pkg::OP_OR_WW: cycles_of = cx_pkg::CYC_OR_SHORT;
         cx_pkg::OP_OR_WI, cx_pkg::OP_OR_RR, cx_pkg::OP_OR_RI,
         cx_pkg::OP_OR_IM: cycles_of = cx_pkg::CYC_OR_LONG;
         default: cycles_of = cx_pkg::CYC_ILLEGAL;
      endcase
   endfunction

   // Instruction classes
   wire logic [7:0] op = ins_reg.op;
   wire logic is_store = op == cx_pkg::OP_ST_DEC || op == cx_pkg::OP_ST_INC;
   wire logic is_lw = op == cx_pkg::OP_LW_RR || op == cx_pkg::OP_LW_IR
      || op == cx_pkg::OP_LW_IM;
   wire logic is_mul = op == cx_pkg::OP_MUL_R || op == cx_pkg::OP_MUL_IR
      || op == cx_pkg::OP_MUL_IM;
   wire logic is_or = op == cx_pkg::OP_OR_WW || op == cx_pkg::OP_OR_WI
      || op == cx_pkg::OP_OR_RR || op == cx_pkg::OP_OR_RI
      || op == cx_pkg::OP_OR_IM;
   wire logic is_next = op == cx_pkg::OP_NEXT;
   wire logic running = state_reg == cx_pkg::CX_RUN;
   wire logic last = running & (cnt_reg == len_reg - 5'h01);
   wire logic [7:0] w_hi = {4'h0, ins_reg.b1[7:4]};
   wire logic [7:0] w_lo = {4'h0, ins_reg.b1[3:0]};

   // Store: low bit of the pair number picks the memory, not the register
   wire logic [7:0] ptr_a = {4'h0, ins_reg.b1[3:1], 1'b0};
   wire logic [7:0] ptr_a1 = ptr_a + 8'h01;
   wire logic [15:0] ptr_word = {rf_reg[ptr_a], rf_reg[ptr_a1]};
   wire logic [15:0] ptr_new = (op == cx_pkg::OP_ST_DEC) ?
      ptr_word - 16'h0001 : ptr_word + 16'h0001;

   // Word load
   wire logic [7:0] lw_a = (op == cx_pkg::OP_LW_IR) ?
      rf_reg[ins_reg.b1] : ins_reg.b1;
   wire logic [7:0] lw_a1 = lw_a + 8'h01;
   wire logic [15:0] lw_word = (op == cx_pkg::OP_LW_IM) ?
      {ins_reg.b2, ins_reg.b3} : {rf_reg[lw_a], rf_reg[lw_a1]};
   wire logic [7:0] lw_d = (op == cx_pkg::OP_LW_IM) ?
      ins_reg.b1 : ins_reg.b2;
   wire logic [7:0] lw_d1 = lw_d + 8'h01;

   // Multiply
   wire logic [7:0] mul_src = (op == cx_pkg::OP_MUL_IM) ? ins_reg.b1 :
      (op == cx_pkg::OP_MUL_IR) ? rf_reg[rf_reg[ins_reg.b1]] :
      rf_reg[ins_reg.b1];
   wire logic [7:0] mul_d = {ins_reg.b2[7:1], 1'b0};
   wire logic [7:0] mul_d1 = mul_d + 8'h01;
   wire logic [15:0] product =
      {8'h00, rf_reg[mul_d]} * {8'h00, mul_src};

   // Logical OR
   wire logic short_or = op == cx_pkg::OP_OR_WW || op == cx_pkg::OP_OR_WI;
   wire logic [7:0] or_sa = short_or ? w_lo : ins_reg.b1;
   wire logic [7:0] or_d = short_or ? w_hi :
      (op == cx_pkg::OP_OR_IM) ? ins_reg.b1 : ins_reg.b2;
   wire logic [7:0] or_s = (op == cx_pkg::OP_OR_IM) ? ins_reg.b2 :
      (op == cx_pkg::OP_OR_WI || op == cx_pkg::OP_OR_RI) ?
      rf_reg[rf_reg[or_sa]] : rf_reg[or_sa];
   wire logic [7:0] or_res = rf_reg[or_d] | or_s;

   // Register file write ports
   wire logic ptr_step = running & is_store & (cnt_reg == cx_pkg::STEP_PTR);
   wire logic wr_pair = ptr_step | (last & (is_lw | is_mul));
   wire logic wr_one = last & is_or;
   wire logic [7:0] wa0 = ptr_step ? ptr_a : is_lw ? lw_d : mul_d;
   wire logic [7:0] wa1 = ptr_step ? ptr_a1 : is_lw ? lw_d1 : mul_d1;
   wire logic [15:0] wd = ptr_step ? ptr_new : is_lw ? lw_word : product;

   always_ff @(posedge clock) begin
      if (sw_rf_wr) begin
         rf_reg[rf_idx] <= avs_writedata[7:0];
      end else if (wr_pair) begin
         rf_reg[wa0] <= wd[15:8];
         rf_reg[wa1] <= wd[7:0];
      end else if (wr_one) begin
         rf_reg[or_d] <= or_res;
      end
   end

   // Flags; the store, load, jump and no-op paths never reach here
   always_comb begin
      flags_next = flags_reg;
      if (sw_wr & hit_flags & avs_byteenable[0]) begin
         flags_next = avs_writedata[7:0];
      end else if (last & is_mul) begin
         flags_next[cx_pkg::FL_C] = product[15:8] != 8'h00;
         flags_next[cx_pkg::FL_Z] = product == 16'h0000;
         flags_next[cx_pkg::FL_S] = product[15];
         flags_next[cx_pkg::FL_V] = 1'b0;
      end else if (last & is_or) begin
         flags_next[cx_pkg::FL_Z] = or_res == 8'h00;
         flags_next[cx_pkg::FL_S] = or_res[7];
         flags_next[cx_pkg::FL_V] = 1'b0;
      end
   end

   // Memory port: store write and the two reads of the next-word jump
   always_comb begin
      mem_next = mem_reg;
      mem_next.write = 1'b0;
      mem_next.read = 1'b0;
      if (running & is_store & (cnt_reg == cx_pkg::STEP_MEM)) begin
         mem_next.addr = ptr_word;
         mem_next.wdata = rf_reg[w_hi];
         mem_next.write = 1'b1;
         mem_next.prog = ~ins_reg.b1[0];
      end else if (running & is_next & (cnt_reg == cx_pkg::STEP_PTR)) begin
         mem_next.addr = tptr_reg;
         mem_next.read = 1'b1;
         mem_next.prog = 1'b1;
      end else if (running & is_next & (cnt_reg == cx_pkg::STEP_MEM)) begin
         mem_next.addr = tptr_reg + 16'h0001;
         mem_next.read = 1'b1;
         mem_next.prog = 1'b1;
      end
   end

   // Sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cx_pkg::CX_IDLE: begin
            if (launch) begin
               state_next = cx_pkg::CX_RUN;
            end
         end
         cx_pkg::CX_RUN: begin
            if (last) begin
               state_next = cx_pkg::CX_IDLE;
            end
         end
         default: state_next = cx_pkg::CX_IDLE;
      endcase
   end

   // Read mux; reads answer even while a run is going on
   wire logic [31:0] rd_mux = hit_ctrl ? ins_reg :
      hit_status ? {30'h0, illegal_reg, running} :
      hit_flags ? {24'h0, flags_reg} :
      hit_pc ? {16'h0, pc_reg} :
      hit_tptr ? {16'h0, tptr_reg} :
      hit_rf ? {24'h0, rf_reg[rf_idx]} : 32'h0;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= cx_pkg::CX_IDLE;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0;
         mem_reg <= '0;
         flags_reg <= cx_pkg::FLAGS_RESET;
         cnt_reg <= 5'h00;
      end else begin
         state_reg <= state_next;
         // Writes are held off while busy so software never races a run
         wait_reg <= ~(req & wait_reg & ~stall);
         rdata_reg <= (req & wait_reg) ? rd_mux : rdata_reg;
         mem_reg <= mem_next;
         flags_reg <= flags_next;
         cnt_reg <= launch ? 5'h00 : running ? cnt_reg + 5'h01 : cnt_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ins_reg <= '0;
         len_reg <= cx_pkg::CYC_ILLEGAL;
         illegal_reg <= 1'b0;
         pc_reg <= cx_pkg::WORD_RESET;
         tptr_reg <= cx_pkg::WORD_RESET;
         hi_reg <= 8'h00;
         lo_reg <= 8'h00;
      end else begin
         if (launch) begin
            ins_reg <= avs_writedata;
            len_reg <= cycles_of(avs_writedata[7:0]);
            illegal_reg <= cycles_of(avs_writedata[7:0])
               == cx_pkg::CYC_ILLEGAL;
         end
         if (running & is_next & (cnt_reg == cx_pkg::STEP_RD_HI)) begin
            hi_reg <= mem_rdata;
         end
         if (running & is_next & (cnt_reg == cx_pkg::STEP_RD_LO)) begin
            lo_reg <= mem_rdata;
         end
         if (last & is_next) begin
            pc_reg <= {hi_reg, lo_reg};
            tptr_reg <= tptr_reg + 16'h0002;
         end else begin
            if (sw_wr & hit_pc) begin
               pc_reg <= merge16(pc_reg, avs_writedata, avs_byteenable);
            end
            if (sw_wr & hit_tptr) begin
               tptr_reg <= merge16(tptr_reg, avs_writedata, avs_byteenable);
            end
         end
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign mem_req = mem_reg;
   assign pc = pc_reg;
   assign busy = state_reg == cx_pkg::CX_RUN;

   // Checking helpers
   logic [4:0] run_len;
   logic [15:0] ptr_start, tptr_start;
   logic running_d;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         run_len <= 5'h00;
         ptr_start <= 16'h0000;
         tptr_start <= 16'h0000;
         running_d <= 1'b0;
      end else begin
         run_len <= launch ? 5'h00 : running ? run_len + 5'h01 : run_len;
         running_d <= running;
         if (running & (cnt_reg == cx_pkg::STEP_PTR)) begin
            ptr_start <= ptr_word;
            tptr_start <= tptr_reg;
         end
      end
   end
   // Delay cleared by reset, so no false end of run follows a reset
   wire logic done = !running & running_d;
   wire logic [15:0] mul_after = {rf_reg[mul_d], rf_reg[mul_d1]};

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_predec_addr: assert property (mem_reg.write && op == cx_pkg::OP_ST_DEC
      |-> mem_reg.addr == ptr_start - 16'h0001)
      else $error("predecrement store used wrong address");
   a_preinc_addr: assert property (mem_reg.write && op == cx_pkg::OP_ST_INC
      |-> mem_reg.addr == ptr_start + 16'h0001)
      else $error("preincrement store used wrong address");
   a_store_space: assert property (mem_reg.write
      |-> mem_reg.prog == !ins_reg.b1[0])
      else $error("store went to wrong memory");
   a_store_time: assert property (done && is_store
      |-> run_len == 5'd14)
      else $error("store did not take 14 cycles");
   a_flags_kept: assert property (running && (is_store || is_lw
      || is_next || op == cx_pkg::OP_NOP) |=> $stable(flags_reg))
      else $error("flags changed by a flag-neutral instruction");
   a_lw_time: assert property (done && is_lw |-> run_len == 5'd8)
      else $error("word load did not take 8 cycles");
   a_mul_flags: assert property (done && is_mul |->
      flags_reg[cx_pkg::FL_C] == (mul_after > 16'd255)
      && flags_reg[cx_pkg::FL_Z] == (mul_after == 16'h0000)
      && flags_reg[cx_pkg::FL_S] == mul_after[15]
      && !flags_reg[cx_pkg::FL_V]
      && flags_reg[cx_pkg::FL_H] == $past(flags_reg[cx_pkg::FL_H], 2))
      else $error("multiply flags wrong");
   a_mul_time: assert property (done && is_mul |-> run_len == 5'd22)
      else $error("multiply did not take 22 cycles");
   a_next_ptr: assert property (done && is_next
      |-> tptr_reg == tptr_start + 16'h0002 && run_len == 5'd10)
      else $error("next-word jump pointer or timing wrong");
   a_nop_time: assert property (done && op == cx_pkg::OP_NOP
      |-> run_len == 5'd4 && $stable(pc_reg))
      else $error("no-operation timing wrong");
   a_or_flags: assert property (done && is_or
      |-> flags_reg[cx_pkg::FL_Z] == (rf_reg[or_d] == 8'h00)
      && flags_reg[cx_pkg::FL_S] == rf_reg[or_d][7]
      && !flags_reg[cx_pkg::FL_V]
      && flags_reg[cx_pkg::FL_C] == $past(flags_reg[cx_pkg::FL_C], 2))
      else $error("logical OR flags wrong");
   a_or_time: assert property (done && is_or |-> run_len ==
      (op == cx_pkg::OP_OR_WW ? 5'd4 : 5'd6))
      else $error("logical OR timing wrong");

   c_store: cover property (mem_reg.write ##1 !mem_reg.write);
   c_next: cover property (done && is_next);
   c_mul_big: cover property (done && is_mul && flags_reg[cx_pkg::FL_C]);
   c_stall: cover property (avs_write && wait_reg && running);
endmodule // cx_exec

// ==== test/cx_mem_model.sv ====
`timescale 1ns/10ps
module cx_mem_model (
   input wire logic clock,
   input wire cx_pkg::cx_mem_req_t mem_req,
   output logic [7:0] mem_rdata
);
   logic [7:0] prog_mem [0:65535];
   logic [7:0] data_mem [0:65535];
   logic [15:0] last_addr;
   logic [7:0] last_data;
   logic last_prog;

   initial begin
      mem_rdata = 8'h00;
      last_addr = 16'h0000;
      last_data = 8'h00;
      last_prog = 1'b0;
   end

   always @(posedge clock) begin
      if (mem_req.write) begin
         last_addr <= mem_req.addr;
         last_data <= mem_req.wdata;
         last_prog <= mem_req.prog;
         if (mem_req.prog) prog_mem[mem_req.addr] <= mem_req.wdata;
         else data_mem[mem_req.addr] <= mem_req.wdata;
      end
      // Data is good only in the cycle after the pulse; after that the bus
      // is inverted every cycle, so a sample one cycle late by the design shows up
      if (mem_req.read) begin
         mem_rdata <= mem_req.prog ? prog_mem[mem_req.addr] :
                      data_mem[mem_req.addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule // cx_mem_model

// ==== test/tb.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb;
   logic clock = 1'b0;
   logic rst_n;
   logic [10:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   cx_pkg::cx_mem_req_t mem_req;
   logic [7:0] mem_rdata;
   logic [15:0] pc;
   logic busy;
   logic [31:0] rd;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int busy_cnt = 0;
   localparam int CEIL = 5000;

   cx_exec i_cx_exec (.clock(clock), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
      .mem_rdata(mem_rdata), .pc(pc), .busy(busy));
   cx_mem_model i_cx_mem_model (.clock(clock), .mem_req(mem_req),
      .mem_rdata(mem_rdata));

   always #5 clock = ~clock;

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (busy === 1'b1) busy_cnt++;
      if (cycles == CEIL) begin
         bad_count++;
         final_report;
      end
   end

   task automatic bus(input logic wr, input logic [10:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // One idle edge so the next request is not driven in this time step
      @(posedge clock);
   endtask

   task automatic setr(input logic [7:0] n, input logic [7:0] v);
      bus(1'b1, cx_pkg::OFS_RF + {1'b0, n, 2'b00}, {24'h000000, v}, 4'h1);
   endtask

   task automatic chk_rd(input logic [10:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000, 4'hf);
      `CHK(rd, e)
   endtask

   task automatic chk_reg(input logic [7:0] n, input logic [7:0] v);
      chk_rd(cx_pkg::OFS_RF + {1'b0, n, 2'b00}, {24'h000000, v});
   endtask

   task automatic flags(input logic [7:0] v);
      bus(1'b1, cx_pkg::OFS_FLAGS, {24'h000000, v}, 4'h1);
   endtask

   task automatic exec(input logic [31:0] ins, input logic [4:0] n);
      busy_cnt = 0;
      bus(1'b1, cx_pkg::OFS_CTRL, ins, 4'hf);
      while (busy !== 1'b0) @(posedge clock);
      `CHK(busy_cnt, int'(n))
   endtask

   task automatic chk_mem(input logic [15:0] a, input logic [7:0] d,
                          input logic p);
      `CHK({i_cx_mem_model.last_addr, i_cx_mem_model.last_data,
            i_cx_mem_model.last_prog}, {a, d, p})
   endtask

   task automatic t_reset;
      `CHK({pc, busy, mem_req}, 44'h00000000000)
      chk_rd(cx_pkg::OFS_STATUS, 32'h00000000);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h00000000);
      chk_rd(cx_pkg::OFS_PC, 32'h00000000);
      chk_rd(cx_pkg::OFS_TPTR, 32'h00000000);
      bus(1'b1, 11'h020, 32'h000000a5, 4'hf);
      chk_rd(11'h020, 32'h00000000);
   endtask

   task automatic t_store;
      flags(8'hfc);
      setr(8'h00, 8'h77);
      setr(8'h06, 8'h30);
      setr(8'h07, 8'h00);
      exec(32'h000006f2, cx_pkg::CYC_STORE);
      chk_mem(16'h2fff, 8'h77, 1'b1);
      exec(32'h000007f2, cx_pkg::CYC_STORE);
      chk_mem(16'h2ffe, 8'h77, 1'b0);
      setr(8'h06, 8'h21);
      setr(8'h07, 8'hff);
      setr(8'h00, 8'h7f);
      exec(32'h000006f3, cx_pkg::CYC_STORE);
      chk_mem(16'h2200, 8'h7f, 1'b1);
      exec(32'h000007f3, cx_pkg::CYC_STORE);
      chk_mem(16'h2201, 8'h7f, 1'b0);
      chk_reg(8'h06, 8'h22);
      chk_reg(8'h07, 8'h01);
      chk_reg(8'h00, 8'h7f);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h000000fc);
   endtask

   task automatic t_lw;
      setr(8'h04, 8'h06);
      setr(8'h05, 8'h1c);
      exec(32'h000604c4, cx_pkg::CYC_LW);
      chk_reg(8'h06, 8'h06);
      chk_reg(8'h07, 8'h1c);
      chk_reg(8'h04, 8'h06);
      setr(8'h08, 8'h02);
      setr(8'h02, 8'h03);
      setr(8'h03, 8'h0f);
      exec(32'h000408c5, cx_pkg::CYC_LW);
      chk_reg(8'h04, 8'h03);
      chk_reg(8'h05, 8'h0f);
      chk_reg(8'h08, 8'h02);
      exec(32'h341206c6, cx_pkg::CYC_LW);
      chk_reg(8'h06, 8'h12);
      chk_reg(8'h07, 8'h34);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h000000fc);
   endtask

   task automatic t_next_nop;
      i_cx_mem_model.prog_mem[16'h1000] = 8'hab;
      i_cx_mem_model.prog_mem[16'h1001] = 8'hcd;
      bus(1'b1, cx_pkg::OFS_TPTR, 32'h00001000, 4'hf);
      exec(32'h0000000f, cx_pkg::CYC_NEXT);
      `CHK(pc, 16'habcd)
      chk_rd(cx_pkg::OFS_TPTR, 32'h00001002);
      exec(32'h000000ff, cx_pkg::CYC_NOP);
      `CHK(pc, 16'habcd)
      chk_rd(cx_pkg::OFS_TPTR, 32'h00001002);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h000000fc);
   endtask

   task automatic t_unsigned_multiply;
      flags(8'h14);
      setr(8'h00, 8'h20);
      setr(8'h02, 8'h09);
      exec(32'h00000284, cx_pkg::CYC_MUL);
      chk_reg(8'h00, 8'h01);
      chk_reg(8'h01, 8'h20);
      chk_reg(8'h02, 8'h09);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h00000084);
      setr(8'h00, 8'h00);
      exec(32'h00003086, cx_pkg::CYC_MUL);
      chk_reg(8'h01, 8'h00);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h00000044);
      setr(8'h00, 8'hff);
      setr(8'h09, 8'h0a);
      setr(8'h0a, 8'hff);
      // Odd destination number still names the pair 0 and 1
      exec(32'h00010985, cx_pkg::CYC_MUL);
      chk_reg(8'h00, 8'hfe);
      chk_reg(8'h01, 8'h01);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h000000a4);
   endtask

   task automatic t_or;
      flags(8'hfc);
      setr(8'h00, 8'h15);
      setr(8'h01, 8'h2a);
      exec(32'h00000142, cx_pkg::CYC_OR_SHORT);
      chk_reg(8'h00, 8'h3f);
      chk_reg(8'h01, 8'h2a);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h0000008c);
      setr(8'h00, 8'h80);
      setr(8'h01, 8'h00);
      setr(8'h02, 8'h01);
      exec(32'h00000243, cx_pkg::CYC_OR_LONG);
      chk_reg(8'h00, 8'h80);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h000000ac);
      setr(8'h05, 8'h00);
      exec(32'h00000546, cx_pkg::CYC_OR_LONG);
      chk_reg(8'h05, 8'h00);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h000000cc);
      setr(8'h00, 8'h15);
      setr(8'h01, 8'h2a);
      exec(32'h00000144, cx_pkg::CYC_OR_LONG);
      chk_reg(8'h00, 8'h3f);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h0000008c);
      setr(8'h00, 8'h08);
      setr(8'h08, 8'h8a);
      setr(8'h01, 8'h37);
      exec(32'h00010045, cx_pkg::CYC_OR_LONG);
      chk_reg(8'h01, 8'hbf);
      chk_reg(8'h08, 8'h8a);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h000000ac);
   endtask

   // A write raised during a run must wait until the run has ended
   task automatic t_stall;
      busy_cnt = 0;
      bus(1'b1, cx_pkg::OFS_CTRL, 32'h000000ff, 4'hf);
      `CHK(busy, 1'b1)
      flags(8'h3c);
      `CHK(busy_cnt, int'(cx_pkg::CYC_NOP))
      chk_rd(cx_pkg::OFS_FLAGS, 32'h0000003c);
   endtask

   task automatic t_midreset;
      bus(1'b1, cx_pkg::OFS_CTRL, 32'h0000000f, 4'hf);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      `CHK({pc, busy, mem_req, avs_waitrequest}, 45'h000000000001)
      chk_rd(cx_pkg::OFS_TPTR, 32'h00000000);
      chk_rd(cx_pkg::OFS_FLAGS, 32'h00000000);
      exec(32'h000000ff, cx_pkg::CYC_NOP);
   endtask

   initial begin
      rst_n = 1'b0;
      avs_address = 11'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_reset;
      t_store;
      t_lw;
      t_next_nop;
      t_unsigned_multiply;
      t_or;
      t_stall;
      t_midreset;
      final_report;
   end
endmodule // tb
